// File: hdl/dpcsr_regs.v
// Purpose: Configuration and session register bank, two access ports
// Assumes: Both ports are synchronous to clk, accesses are one-cycle strobes
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps
`include "dpcsr_map.vh"
module dpcsr_regs
#(
   parameter [7:0] CFG_CTRL_RST = 8'h01
)
(
   input  wire       clk,
   input  wire       rst,
   input  wire       i2cWrEn,
   input  wire       i2cRdEn,
   input  wire [3:0] i2cAddr,
   input  wire [7:0] i2cWrData,
   output reg  [7:0] i2cRdData,
   input  wire       nfcWrEn,
   input  wire       nfcRdEn,
   input  wire [3:0] nfcAddr,
   input  wire [7:0] nfcWrData,
   output reg  [7:0] nfcRdData,
   output wire       bankReady,
   input  wire       nfcActive,
   input  wire       i2cActive,
   input  wire       vccPresent,
   input  wire       authExhausted,
   input  wire       msgReadDone,
   input  wire       i2cTakeMem,
   input  wire       rfOwnsMem,
   input  wire       bufReadyI2c,
   input  wire       bufReadyNfc,
   input  wire       memWrFail,
   input  wire       memWrBusy,
   input  wire       fieldPresent,
   input  wire       wdtExpired,
   input  wire       i2cBusy,
   output wire [7:0] sessionControl,
   output wire [7:0] lastMessageBlock,
   output wire [7:0] mirrorBlock,
   output wire [15:0] watchdogReload,
   output wire       clockStretchEnable,
   output wire       i2cOwnsMem,
   output wire       configFrozen,
   output reg        detectRelease
);

   // ------------------------------------------------------------
   // Power-up load sequencer
   // ------------------------------------------------------------
   localparam ST_LOAD = 1'b0;
   localparam ST_RUN  = 1'b1;

   reg state_ff;

   always @(posedge clk)
   begin
      if (rst)
         state_ff <= ST_LOAD;
      else
      begin
         case (state_ff)
            ST_LOAD: state_ff <= ST_RUN;
            default: state_ff <= ST_RUN;
         endcase
      end
   end

   wire loading = (state_ff == ST_LOAD);
   assign bankReady = ~loading;

   // ------------------------------------------------------------
   // Write qualification
   // ------------------------------------------------------------
   wire lockI2c;
   wire lockNfc;
   wire i2cWr = i2cWrEn & bankReady;
   wire nfcWr = nfcWrEn & bankReady;
   wire i2cRd = i2cRdEn & bankReady;
   wire nfcRd = nfcRdEn & bankReady;

   wire cfgWrI2c = i2cWr & ~lockI2c;
   wire cfgWrNfc = nfcWr & ~lockNfc;
   wire cfgWr    = cfgWrI2c | cfgWrNfc;
   wire [3:0] cfgAddr = cfgWrI2c ? i2cAddr : nfcAddr;
   wire [7:0] cfgData = cfgWrI2c ? i2cWrData : nfcWrData;

   assign configFrozen = lockI2c & lockNfc;

   // ------------------------------------------------------------
   // Configuration bytes
   // ------------------------------------------------------------
   reg [7:0] cfgCtrl_ff;
   reg [7:0] cfgLast_ff;
   reg [7:0] cfgMirr_ff;
   reg [7:0] cfgWdtl_ff;
   reg [7:0] cfgWdth_ff;
   reg       cfgStr_ff;

   always @(posedge clk)
   begin
      if (rst)
      begin
         cfgCtrl_ff <= CFG_CTRL_RST;
         cfgLast_ff <= `DPCSR_RST_LAST;
         cfgMirr_ff <= `DPCSR_RST_MIRR;
         cfgWdtl_ff <= `DPCSR_RST_WDTL;
         cfgWdth_ff <= `DPCSR_RST_WDTH;
         cfgStr_ff  <= `DPCSR_RST_STR;
      end
      else if (cfgWr)
      begin
         if (cfgAddr == `DPCSR_CFG_CTRL)
            cfgCtrl_ff <= cfgData;
         else if (cfgAddr == `DPCSR_CFG_LAST)
            cfgLast_ff <= cfgData;
         else if (cfgAddr == `DPCSR_CFG_MIRR)
            cfgMirr_ff <= cfgData;
         else if (cfgAddr == `DPCSR_CFG_WDTL)
            cfgWdtl_ff <= cfgData;
         else if (cfgAddr == `DPCSR_CFG_WDTH)
            cfgWdth_ff <= cfgData;
         else if (cfgAddr == `DPCSR_CFG_STR)
            cfgStr_ff <= cfgData[`DPCSR_STR_EN];
      end
   end

   assign clockStretchEnable = cfgStr_ff;

   // ------------------------------------------------------------
   // One-time lock bits
   // ------------------------------------------------------------
   wire lockWrI2c = cfgWrI2c & (i2cAddr == `DPCSR_CFG_LOCK);
   wire lockWrNfc = cfgWrNfc & ~cfgWrI2c &
                    (nfcAddr == `DPCSR_CFG_LOCK);
   wire lockWr = lockWrI2c | lockWrNfc;

   dpcsr_sticky_bit u_lock_i2c
   (
      .clk      (clk),
      .rst      (rst),
      .setPulse (lockWr & cfgData[`DPCSR_LOCK_I2C]),
      .clrPulse (1'b0),
      .flag     (lockI2c)
   );

   dpcsr_sticky_bit u_lock_nfc
   (
      .clk      (clk),
      .rst      (rst),
      .setPulse (lockWr & cfgData[`DPCSR_LOCK_NFC]),
      .clrPulse (1'b0),
      .flag     (lockNfc)
   );

   // ------------------------------------------------------------
   // Session bytes, written from I2C only
   // ------------------------------------------------------------
   reg [7:0] sesCtrl_ff;
   reg [7:0] sesLast_ff;
   reg [7:0] sesMirr_ff;
   reg [7:0] sesWdtl_ff;
   reg [7:0] sesWdth_ff;
   reg [7:0] nxt_sesCtrl;

   wire sesWr = i2cWr;

   always @*
   begin
      nxt_sesCtrl = sesCtrl_ff;
      if (sesWr && i2cAddr == `DPCSR_SES_CTRL)
         nxt_sesCtrl = i2cWrData;
      if (~nfcActive | ~i2cActive)
         nxt_sesCtrl[`DPCSR_CTRL_PTHRU] = 1'b0;
      if (~vccPresent)
         nxt_sesCtrl[`DPCSR_CTRL_MIRR] = 1'b0;
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         sesCtrl_ff <= `DPCSR_ZERO8;
         sesLast_ff <= `DPCSR_ZERO8;
         sesMirr_ff <= `DPCSR_ZERO8;
         sesWdtl_ff <= `DPCSR_ZERO8;
         sesWdth_ff <= `DPCSR_ZERO8;
      end
      else if (loading)
      begin
         sesCtrl_ff <= cfgCtrl_ff;
         sesLast_ff <= cfgLast_ff;
         sesMirr_ff <= cfgMirr_ff;
         sesWdtl_ff <= cfgWdtl_ff;
         sesWdth_ff <= cfgWdth_ff;
      end
      else
      begin
         sesCtrl_ff <= nxt_sesCtrl;
         if (sesWr)
         begin
            if (i2cAddr == `DPCSR_SES_LAST)
               sesLast_ff <= i2cWrData;
            else if (i2cAddr == `DPCSR_SES_MIRR)
               sesMirr_ff <= i2cWrData;
            else if (i2cAddr == `DPCSR_SES_WDTL)
               sesWdtl_ff <= i2cWrData;
            else if (i2cAddr == `DPCSR_SES_WDTH)
               sesWdth_ff <= i2cWrData;
         end
      end
   end

   assign sessionControl   = sesCtrl_ff;
   assign lastMessageBlock = sesLast_ff;
   assign mirrorBlock      = sesMirr_ff;

   // ------------------------------------------------------------
   // Watchdog reload, taken on a high-byte write
   // ------------------------------------------------------------
   reg  [15:0] wdtReload_ff;
   reg  [15:0] nxt_wdtReload;

   always @*
   begin
      nxt_wdtReload = wdtReload_ff;
      if (loading)
         nxt_wdtReload = {cfgWdth_ff, cfgWdtl_ff};
      else if (sesWr && i2cAddr == `DPCSR_SES_WDTH)
         nxt_wdtReload = {i2cWrData, sesWdtl_ff};
      else if (cfgWr && cfgAddr == `DPCSR_CFG_WDTH)
         nxt_wdtReload = {cfgData, cfgWdtl_ff};
      if (nxt_wdtReload < `DPCSR_WDT_MIN)
         nxt_wdtReload = `DPCSR_WDT_MIN;
   end

   always @(posedge clk)
   begin
      if (rst)
         wdtReload_ff <= {`DPCSR_RST_WDTH, `DPCSR_RST_WDTL};
      else
         wdtReload_ff <= nxt_wdtReload;
   end

   assign watchdogReload = wdtReload_ff;

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   wire msgRead;
   wire wrErr;
   wire statRdI2c = i2cRd & (i2cAddr == `DPCSR_SES_STAT);
   wire statRdNfc = nfcRd & (nfcAddr == `DPCSR_SES_STAT);
   wire statWrI2c = i2cWr & (i2cAddr == `DPCSR_SES_STAT);
   reg  wdtPend_ff;

   dpcsr_sticky_bit u_msg_read
   (
      .clk      (clk),
      .rst      (rst),
      .setPulse (msgReadDone),
      .clrPulse (statRdI2c | statRdNfc),
      .flag     (msgRead)
   );

   // Expiry waits for the running I2C transaction to end
   always @(posedge clk)
   begin
      if (rst)
         wdtPend_ff <= 1'b0;
      else if (wdtExpired & i2cBusy)
         wdtPend_ff <= 1'b1;
      else if (~i2cBusy)
         wdtPend_ff <= 1'b0;
   end

   wire wdtRelease = (wdtExpired | wdtPend_ff) & ~i2cBusy;
   wire hostRelease = statWrI2c & ~i2cWrData[`DPCSR_ST_I2COWN];

   dpcsr_sticky_bit u_i2c_own
   (
      .clk      (clk),
      .rst      (rst),
      .setPulse (i2cTakeMem),
      .clrPulse (hostRelease | wdtRelease),
      .flag     (i2cOwnsMem)
   );

   dpcsr_sticky_bit u_wr_err
   (
      .clk      (clk),
      .rst      (rst),
      .setPulse (memWrFail),
      .clrPulse (statWrI2c & ~i2cWrData[`DPCSR_ST_WRERR]),
      .flag     (wrErr)
   );

   reg [4:0] stLevels_ff;
   reg       authDone_ff;

   always @(posedge clk)
   begin
      if (rst)
      begin
         stLevels_ff <= 5'h00;
         authDone_ff <= 1'b0;
      end
      else
      begin
         stLevels_ff <= {rfOwnsMem, bufReadyI2c, bufReadyNfc,
                         memWrBusy, fieldPresent};
         authDone_ff <= authExhausted;
      end
   end

   wire [7:0] statusByte = {msgRead, i2cOwnsMem, stLevels_ff[4:2],
                            wrErr, stLevels_ff[1:0]};
   wire [7:0] strByte = {6'h00, authDone_ff, cfgStr_ff};

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   function [7:0] rd_mux;
      input [3:0] a;
      begin
         if (a == `DPCSR_CFG_CTRL)
            rd_mux = cfgCtrl_ff;
         else if (a == `DPCSR_CFG_LAST)
            rd_mux = cfgLast_ff;
         else if (a == `DPCSR_CFG_MIRR)
            rd_mux = cfgMirr_ff;
         else if (a == `DPCSR_CFG_WDTL)
            rd_mux = cfgWdtl_ff;
         else if (a == `DPCSR_CFG_WDTH)
            rd_mux = cfgWdth_ff;
         else if (a == `DPCSR_CFG_STR)
            rd_mux = {7'h00, cfgStr_ff};
         else if (a == `DPCSR_CFG_LOCK)
            rd_mux = {6'h00, lockI2c, lockNfc};
         else if (a == `DPCSR_SES_CTRL)
            rd_mux = sesCtrl_ff;
         else if (a == `DPCSR_SES_LAST)
            rd_mux = sesLast_ff;
         else if (a == `DPCSR_SES_MIRR)
            rd_mux = sesMirr_ff;
         else if (a == `DPCSR_SES_WDTL)
            rd_mux = sesWdtl_ff;
         else if (a == `DPCSR_SES_WDTH)
            rd_mux = sesWdth_ff;
         else if (a == `DPCSR_SES_STR)
            rd_mux = strByte;
         else if (a == `DPCSR_SES_STAT)
            rd_mux = statusByte;
         else
            rd_mux = `DPCSR_ZERO8;
      end
   endfunction

   always @(posedge clk)
   begin
      if (rst)
      begin
         i2cRdData     <= `DPCSR_ZERO8;
         nfcRdData     <= `DPCSR_ZERO8;
         detectRelease <= 1'b0;
      end
      else
      begin
         if (i2cRd)
            i2cRdData <= rd_mux(i2cAddr);
         if (nfcRd)
            nfcRdData <= rd_mux(nfcAddr);
         detectRelease <= statRdI2c &
            (sesCtrl_ff[`DPCSR_CTRL_FDON] == `DPCSR_FDON_FIELD);
      end
   end

endmodule

// File: hdl/dpcsr_map.vh
// Purpose: Constants for the dual-port configuration and session bank
// Assumes: 4-bit register index shared by the I2C and contactless ports
// Notes:   Indices 0-6 hold configuration bytes, 8-e session bytes
//
// Behaviour
// - Watchdog high config resets 08h; writing it activates high and low.
// - Stretch config bit 0 enables clock stretching, default 1, both ports.
// - Lock bit 1 set blocks I2C config writes, never clears.
// - Lock bit 0 set blocks contactless config writes, never clears.
// - Both locks set freeze config; else that port may edit locks.
// - Session bytes read-only from contactless; I2C writes override config.
// - Session control field layout: bits 7,6,5-4,3-2,1,0.
// - Pass-through enable clears when either interface goes inactive.
// - Mirror enable clears when supply power is lost.
// - Session stretch bits 7-2 read zero, bit 0 mirrors, read-only.
// - Session stretch bit 1 shows authentication attempts exhausted.
// - Status bit 7 sets after full message read, clears on read.
// - Status bit 6 shows I2C owns memory; I2C may release it.
// - Status bit 5 shows contactless side owns memory.
// - Status bits 4 and 3 show buffer data waiting per side.
// - Status bit 2 sets on write failure until I2C writes zero.
// - Status bit 1 reads one while memory write is busy.
// - Status bit 0 reads one while carrier field is present.
// - Watchdog reload defaults 848h, range 0001h to FFFFh.
// - Watchdog expiry releases I2C ownership after transaction ends.
// - Field-presence assert mode releases detect output on I2C status read.
`ifndef DPCSR_MAP_VH
`define DPCSR_MAP_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define DPCSR_CFG_CTRL    4'h0
`define DPCSR_CFG_LAST    4'h1
`define DPCSR_CFG_MIRR    4'h2
`define DPCSR_CFG_WDTL    4'h3
`define DPCSR_CFG_WDTH    4'h4
`define DPCSR_CFG_STR     4'h5
`define DPCSR_CFG_LOCK    4'h6
`define DPCSR_SES_CTRL    4'h8
`define DPCSR_SES_LAST    4'h9
`define DPCSR_SES_MIRR    4'ha
`define DPCSR_SES_WDTL    4'hb
`define DPCSR_SES_WDTH    4'hc
`define DPCSR_SES_STR     4'hd
`define DPCSR_SES_STAT    4'he

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DPCSR_RST_LAST    8'h00
`define DPCSR_RST_MIRR    8'hf8
`define DPCSR_RST_WDTL    8'h48
`define DPCSR_RST_WDTH    8'h08
`define DPCSR_RST_STR     1'h1
`define DPCSR_WDT_MIN     16'h0001
`define DPCSR_ZERO8       8'h00

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DPCSR_CTRL_RST    7
`define DPCSR_CTRL_PTHRU  6
`define DPCSR_CTRL_FDOFF  5:4
`define DPCSR_CTRL_FDON   3:2
`define DPCSR_CTRL_MIRR   1
`define DPCSR_CTRL_DIR    0
`define DPCSR_FDON_FIELD  2'h0
`define DPCSR_LOCK_I2C    1
`define DPCSR_LOCK_NFC    0
`define DPCSR_STR_EN      0
`define DPCSR_STR_AUTH    1
`define DPCSR_ST_MSGRD    7
`define DPCSR_ST_I2COWN   6
`define DPCSR_ST_WRERR    2

`endif

// File: hdl/dpcsr_sticky_bit.v
// Purpose: One flag set by hardware and cleared by an access
// Assumes: Set and clear are one-cycle pulses
// Notes:   Set wins over a clear in the same cycle
`timescale 1ns/1ps
module dpcsr_sticky_bit
#(
   parameter RST_VAL = 1'b0
)
(
   input  wire clk,
   input  wire rst,
   input  wire setPulse,
   input  wire clrPulse,
   output wire flag
);

   reg flag_ff;

   always @(posedge clk)
   begin
      if (rst)
         flag_ff <= RST_VAL;
      else if (setPulse)
         flag_ff <= 1'b1;
      else if (clrPulse)
         flag_ff <= 1'b0;
   end

   assign flag = flag_ff;

endmodule

// File: verif/dpcsr_regs_monitor.sv
// Purpose: Port-level checks for the register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module dpcsr_regs_monitor
(
   input wire        clk,
   input wire        rst,
   input wire        bankReady,
   input wire        i2cWrEn,
   input wire        i2cRdEn,
   input wire [3:0]  i2cAddr,
   input wire [7:0]  i2cWrData,
   input wire [7:0]  i2cRdData,
   input wire        nfcActive,
   input wire        i2cActive,
   input wire        vccPresent,
   input wire        rfOwnsMem,
   input wire        bufReadyI2c,
   input wire        bufReadyNfc,
   input wire        memWrBusy,
   input wire        fieldPresent,
   input wire        wdtExpired,
   input wire        i2cBusy,
   input wire        i2cTakeMem,
   input wire [7:0]  sessionControl,
   input wire [15:0] watchdogReload,
   input wire        i2cOwnsMem,
   input wire        configFrozen,
   input wire        detectRelease
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire       i2cWr = bankReady && i2cWrEn;
   wire       rdStat = bankReady && i2cRdEn && i2cAddr == 4'he;
   wire [4:0] lvlIn = {rfOwnsMem, bufReadyI2c, bufReadyNfc, memWrBusy,
                       fieldPresent};
   // ----------------------------------------
   // Port relations
   // ----------------------------------------
   a_ready_load:
      assert property ($fell(rst) |=> bankReady) else $error("no load");
   a_frozen_hold:
      assert property (configFrozen |=> configFrozen) else $error("unlock");
   a_reload_high:
      assert property (i2cWr && i2cAddr == 4'hc |=> watchdogReload[15:8]
         == $past(i2cWrData)) else $error("reload high not taken");
   a_ctrl_write:
      assert property (i2cWr && i2cAddr == 4'h8 |=> sessionControl[5:2]
         == $past(i2cWrData[5:2])) else $error("control fields wrong");
   a_pthru_clear:
      assert property (bankReady && !(nfcActive && i2cActive)
         |=> !sessionControl[6]) else $error("pass-through kept");
   a_mirror_clear:
      assert property (bankReady && !vccPresent |=> !sessionControl[1])
         else $error("mirror kept");
   a_level_bits:
      assert property (rdStat |=> {i2cRdData[5:3], i2cRdData[1:0]}
         == $past(lvlIn, 2)) else $error("status levels wrong");
   a_release_src:
      assert property ($rose(detectRelease) |-> $past(rdStat
         && sessionControl[3:2] == 2'h0)) else $error("stray release");
   a_wdt_free:
      assert property (bankReady && wdtExpired && !i2cBusy && !i2cTakeMem
         |=> !i2cOwnsMem) else $error("ownership kept");
   c_stat_read: cover property (rdStat ##1 detectRelease);
   c_wdt_busy: cover property (wdtExpired && i2cBusy && i2cOwnsMem);
   c_frozen: cover property ($rose(configFrozen));
endmodule

bind dpcsr_regs dpcsr_regs_monitor i_dpcsr_regs_monitor
(
   .clk, .rst, .bankReady, .i2cWrEn, .i2cRdEn, .i2cAddr, .i2cWrData,
   .i2cRdData, .nfcActive, .i2cActive, .vccPresent, .rfOwnsMem,
   .bufReadyI2c, .bufReadyNfc, .memWrBusy, .fieldPresent, .wdtExpired,
   .i2cBusy, .i2cTakeMem, .sessionControl, .watchdogReload, .i2cOwnsMem,
   .configFrozen, .detectRelease
);

// File: verif/dpcsr_peer.sv
// Purpose: Reader, host and memory side sources of status events
// Assumes: Changes land on the falling edge of clk
// Notes:   evt is {expiry, fail, take, msg}; lvl is status levels
`timescale 1ns/1ps
module dpcsr_peer
(
   input  wire       clk,
   output reg  [3:0] evt,
   output reg  [4:0] lvl
);
   initial
   begin
      evt = 4'h0;
      lvl = 5'h00;
   end
   // One-cycle events; bit 2 is a failed memory write
   task pulse(input logic [3:0] m);
      begin
         @(negedge clk);
         evt = m;
         @(negedge clk);
         evt = 4'h0;
      end
   endtask
   task hold(input logic [4:0] v);
      begin
         @(negedge clk);
         lvl = v;
      end
   endtask
endmodule

// File: verif/dpcsr_regs_tb.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Strobes driven on the falling edge of clk
// Notes:   Status sources come from the peer model
`timescale 1ns/1ps
module dpcsr_regs_tb;
   localparam logic I2 = 1'b0;
   localparam logic RF = 1'b1;
   logic        clk, rst, nfcActive, i2cActive, vccPresent;
   logic        i2cWrEn, i2cRdEn, nfcWrEn, nfcRdEn, authExhausted, i2cBusy;
   logic [3:0]  i2cAddr, nfcAddr;
   logic [7:0]  i2cWrData, nfcWrData;
   wire  [7:0]  i2cRdData, nfcRdData, sessionControl, lastMessageBlock;
   wire  [7:0]  mirrorBlock;
   wire  [15:0] watchdogReload;
   wire  [3:0]  evt;
   wire  [4:0]  lvl;
   wire         bankReady, clockStretchEnable, i2cOwnsMem, configFrozen;
   wire         detectRelease;
   int          nMismatch = 0;
   int          checkCount = 0;
   int          cycles = 0;
   // ----------------------------------------
   // Harness
   // ----------------------------------------
   dpcsr_peer i_dpcsr_peer (.clk, .evt, .lvl);
   dpcsr_regs i_dpcsr_regs
   (
      .clk, .rst, .i2cWrEn, .i2cRdEn, .i2cAddr, .i2cWrData, .i2cRdData,
      .nfcWrEn, .nfcRdEn, .nfcAddr, .nfcWrData, .nfcRdData, .bankReady,
      .nfcActive, .i2cActive, .vccPresent, .authExhausted, .i2cBusy,
      .msgReadDone(evt[0]), .i2cTakeMem(evt[1]), .memWrFail(evt[2]),
      .wdtExpired(evt[3]), .rfOwnsMem(lvl[4]), .bufReadyI2c(lvl[3]),
      .bufReadyNfc(lvl[2]), .memWrBusy(lvl[1]), .fieldPresent(lvl[0]),
      .sessionControl, .lastMessageBlock, .mirrorBlock,
      .watchdogReload, .clockStretchEnable, .i2cOwnsMem, .configFrozen,
      .detectRelease
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task print_verdict;
      begin
         if (nMismatch == 0 && checkCount > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   // Tests need about 115 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         nMismatch++;
         print_verdict;
      end
   end
   task chk(input string nm, input logic [15:0] seen, exp);
      begin
         checkCount++;
         if (seen !== exp)
         begin
            nMismatch++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task acc(input logic rf, wr, input logic [3:0] a, input logic [7:0] d);
      begin
         @(negedge clk);
         {nfcWrEn, nfcRdEn} = {rf & wr, rf & ~wr};
         {i2cWrEn, i2cRdEn} = {~rf & wr, ~rf & ~wr};
         {nfcAddr, i2cAddr, nfcWrData, i2cWrData} = {a, a, d, d};
         @(negedge clk);
         {nfcWrEn, nfcRdEn, i2cWrEn, i2cRdEn} = 4'h0;
      end
   endtask
   task wr(input logic rf, input logic [3:0] a, input logic [7:0] d);
      acc(rf, 1'b1, a, d);
   endtask
   task rd(input logic rf, input logic [3:0] a, input logic [7:0] e);
      begin
         acc(rf, 1'b0, a, 8'h00);
         chk($sformatf("reg %h", a), rf ? nfcRdData : i2cRdData, e);
      end
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      {rst, nfcActive, i2cActive, vccPresent} = 4'hf;
      {i2cWrEn, i2cRdEn, nfcWrEn, nfcRdEn, authExhausted, i2cBusy} = 6'h00;
      {i2cAddr, nfcAddr, i2cWrData, nfcWrData} = 24'h000000;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      chk("bankReady", bankReady, 16'h0000);
      rd(I2, 4'h4, 8'h08);
      chk("bankReady", bankReady, 16'h0001);
      rd(I2, 4'h5, 8'h01);
      rd(I2, 4'h6, 8'h00);
      rd(I2, 4'hc, 8'h08);
      rd(RF, 4'hb, 8'h48);
      rd(I2, 4'he, 8'h00);
      chk("watchdogReload", watchdogReload, 16'h0848);
      chk("lastMessageBlock", lastMessageBlock, 16'h0000);
      chk("mirrorBlock", mirrorBlock, 16'h00f8);
      wr(I2, 4'h9, 8'h2a);
      wr(RF, 4'ha, 8'h11);
      chk("lastMessageBlock", lastMessageBlock, 16'h002a);
      chk("mirrorBlock", mirrorBlock, 16'h00f8);
      wr(I2, 4'hb, 8'h34);
      chk("watchdogReload", watchdogReload, 16'h0848);
      wr(I2, 4'hc, 8'h12);
      wr(RF, 4'hc, 8'h77);
      chk("watchdogReload", watchdogReload, 16'h1234);
      rd(RF, 4'hc, 8'h12);
      wr(I2, 4'hb, 8'h00);
      wr(I2, 4'hc, 8'h00);
      chk("watchdogReload", watchdogReload, 16'h0001);
      wr(I2, 4'h8, 8'hbd);
      chk("sessionControl", sessionControl, 16'h00bd);
      for (int k = 0; k < 2; k++)
      begin
         wr(I2, 4'h8, 8'h42);
         {nfcActive, i2cActive} = k ? 2'b10 : 2'b01;
         @(negedge clk);
         chk("sessionControl", sessionControl, 16'h0002);
         {nfcActive, i2cActive} = 2'b11;
      end
      vccPresent = 1'b0;
      @(negedge clk);
      chk("sessionControl", sessionControl, 16'h0000);
      vccPresent = 1'b1;
      wr(I2, 4'h5, 8'h00);
      chk("clockStretchEnable", clockStretchEnable, 16'h0000);
      authExhausted = 1'b1;
      wr(I2, 4'hd, 8'hff);
      rd(RF, 4'hd, 8'h02);
      wr(RF, 4'h5, 8'h01);
      rd(I2, 4'hd, 8'h03);
      wr(I2, 4'h6, 8'h02);
      wr(I2, 4'h4, 8'h55);
      rd(I2, 4'h4, 8'h08);
      wr(RF, 4'h4, 8'h33);
      rd(RF, 4'h4, 8'h33);
      chk("watchdogReload", watchdogReload, 16'h3348);
      wr(RF, 4'h6, 8'h00);
      rd(RF, 4'h6, 8'h02);
      wr(RF, 4'h6, 8'h01);
      chk("configFrozen", configFrozen, 16'h0001);
      wr(RF, 4'h4, 8'h66);
      rd(I2, 4'h6, 8'h03);
      rd(RF, 4'h4, 8'h33);
      i_dpcsr_peer.hold(5'h1f);
      i_dpcsr_peer.pulse(4'h7);
      rd(I2, 4'he, 8'hff);
      chk("detectRelease", detectRelease, 16'h0001);
      rd(I2, 4'he, 8'h7f);
      wr(RF, 4'he, 8'h00);
      rd(RF, 4'he, 8'h7f);
      wr(I2, 4'he, 8'h00);
      rd(I2, 4'he, 8'h3b);
      i_dpcsr_peer.hold(5'h00);
      rd(I2, 4'he, 8'h00);
      i_dpcsr_peer.pulse(4'h2);
      i2cBusy = 1'b1;
      i_dpcsr_peer.pulse(4'h8);
      chk("i2cOwnsMem", i2cOwnsMem, 16'h0001);
      i2cBusy = 1'b0;
      repeat (2) @(negedge clk);
      chk("i2cOwnsMem", i2cOwnsMem, 16'h0000);
      i_dpcsr_peer.pulse(4'h2);
      i_dpcsr_peer.pulse(4'h8);
      chk("i2cOwnsMem", i2cOwnsMem, 16'h0000);
      print_verdict;
   end
endmodule
